// ==== gb_board_model.sv ====
// board model: pin levels seen by the gpio bank, with pull-ups on the open-collector lines
`timescale 1ns/1ns

`include "gb_gpio_bank_defs.svh"

module gb_board_model
	import gb_pkg::*;
(
	input wire logic [`GB_NPIN-1:0] pad_out,
	input wire logic [`GB_NPIN-1:0] pad_oe,
	input wire logic [`GB_NPIN-1:0] ext_lvl,
	output logic [`GB_NPIN-1:0] pad_in
);
	// released lines show the board strap in ext_lvl, or 1 on the open-collector lines, never the last driven value
	always_comb begin
		for (int i = 0; i < `GB_NPIN; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (i >= `GB_P_OC && i < `GB_P_OC + 4)
				pad_in[i] = 1'b1;
			else
				pad_in[i] = ext_lvl[i];
		end
	end
endmodule : gb_board_model

// ==== gb_gpio_bank.sv ====
// multiplexed gpio bank: pin muxing, gpio registers, input synchronisers
`timescale 1ns/1ns

`include "gb_gpio_bank_defs.svh"

module gb_gpio_bank
	import gb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire gb_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	input wire logic [`GB_NPIN-1:0] pad_in,
	output logic [`GB_NPIN-1:0] pad_out,
	output logic [`GB_NPIN-1:0] pad_oe,
	input wire logic [`GB_NPIN-1:0] func_out,
	input wire logic [`GB_NPIN-1:0] func_oe,
	output logic [`GB_NPIN-1:0] func_sel,
	output logic [3:0] audio_hda_route,
	input wire logic [1:0] smbus_oc_mode,
	input wire logic lpc_dma_use,
	input wire logic rtc_internal
);

	gb_regs_t r;
	logic [`GB_NPIN-1:0] sync1;
	logic [`GB_NPIN-1:0] st;
	logic [`GB_NPIN-1:0] tri_v;
	logic [`GB_NPIN-1:0] val_v;
	logic [`GB_NPIN-1:0] ded;
	logic [`GB_NPIN-1:0] park;
	logic [`GB_NPIN-1:0] next_oe;
	logic [`GB_NPIN-1:0] next_out;
	logic [3:0] next_hda;
	logic [7:0] next_rdata;
	logic oc_data;

	function automatic logic hit(input gb_req_t q, input gb_space_t s, input logic [11:0] a);
		hit = (q.space == s) && (q.addr == a);
	endfunction : hit

	function automatic logic nz(input logic [1:0] s);
		nz = (s != 2'b00);
	endfunction : nz

	assign oc_data = hit(reg_req, GB_SP_IO, `GB_OFF_DATA) && (r.idx == `GB_IDX_OC);

	// register writes; reset leaves every gpio as an input
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r.aud_sel <= `GB_RST_ZERO;
			r.aud_oe <= `GB_RST_ALL_IN;
			r.arst_oe <= `GB_RST_ARST_IN;
			r.aud_val <= `GB_RST_ZERO;
			r.arst_val <= `GB_RST_ZERO;
			r.fan_ev <= `GB_RST_HI_IN;
			r.vlo_ev <= `GB_RST_HI_IN;
			r.vhi_ev <= `GB_RST_HI_IN;
			r.tmp_ev <= `GB_RST_HI_IN;
			r.pci_ev <= `GB_RST_HI_IN;
			r.pci_sel <= `GB_RST_ZERO4;
			r.smb_cfg <= `GB_RST_ZERO;
			r.misc_ev <= `GB_RST_HI_IN;
			r.act <= `GB_RST_ACT;
			r.pm_arst <= `GB_RST_ZERO;
			r.pm_fan <= `GB_RST_ZERO;
			r.pm_llb <= `GB_RST_ZERO;
			r.ev8 <= `GB_RST_EV8;
			r.ev_val <= `GB_RST_ZERO;
			r.ev_dir <= `GB_RST_ALL_IN;
			r.fanin_sel <= `GB_RST_ZERO3;
			r.tmp_sel <= `GB_RST_ZERO;
			r.vlo_sel <= `GB_RST_ZERO;
			r.vhi_sel <= `GB_RST_ZERO;
			r.pci_bridge_config_hi <= `GB_RST_ZERO;
			r.idx <= `GB_RST_ZERO;
			r.oc_oe <= `GB_RST_OC;
		end else if (reg_req.wr) begin
			if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_SEL)) r.aud_sel <= reg_req.wdata;
			if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_OE)) r.aud_oe <= reg_req.wdata;
			if (hit(reg_req, GB_SP_EXT, `GB_OFF_ARST_OE)) r.arst_oe <= reg_req.wdata;
			if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_VAL)) r.aud_val <= reg_req.wdata;
			if (hit(reg_req, GB_SP_EXT, `GB_OFF_ARST_VAL)) r.arst_val <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_FAN_EV)) r.fan_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_VLO_EV)) r.vlo_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_VHI_EV)) r.vhi_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_TMP_EV)) r.tmp_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_PCI_EV)) r.pci_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_PCI_SI)) r.pci_sel <= reg_req.wdata[7:4];
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_SMB_CFG)) r.smb_cfg <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_MISC_EV)) r.misc_ev <= reg_req.wdata;
			if (hit(reg_req, GB_SP_SMB, `GB_OFF_ACT)) r.act <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_ARST)) r.pm_arst <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_FAN)) r.pm_fan <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_LLB)) r.pm_llb <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_EV8)) r.ev8 <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_EV_VAL)) r.ev_val <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM, `GB_OFF_EV_DIR)) r.ev_dir <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_FAN_TACH_IN_0)) r.fanin_sel[0] <= reg_req.wdata[0];
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_FANIN1)) r.fanin_sel[1] <= reg_req.wdata[0];
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_FANIN2)) r.fanin_sel[2] <= reg_req.wdata[0];
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_TMP_SEL)) r.tmp_sel <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_VLO_SEL)) r.vlo_sel <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PM2, `GB_OFF_VHI_SEL)) r.vhi_sel <= reg_req.wdata;
			if (hit(reg_req, GB_SP_PCI_BRIDGE_CONFIG, `GB_OFF_PCI_BRIDGE_CONFIG_HI)) r.pci_bridge_config_hi <= reg_req.wdata;
			if (hit(reg_req, GB_SP_IO, `GB_OFF_IDX)) r.idx <= reg_req.wdata;
			if (oc_data) r.oc_oe <= {reg_req.wdata[7:6], reg_req.wdata[3:2]};
		end
	end

	// two-stage synchroniser; only the second stage feeds anything else
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sync1 <= '0;
			st <= '0;
		end else begin
			sync1 <= pad_in;
			st <= sync1;
		end
	end

	// gather per-pin enable (1 = tri-state) and value bits into pin order
	always_comb begin
		tri_v = '1;
		val_v = '0;
		tri_v[`GB_P_AUD +: 4] = r.aud_oe[3:0];
		val_v[`GB_P_AUD +: 4] = r.aud_val[3:0];
		tri_v[`GB_P_ARST] = r.arst_oe[0];
		val_v[`GB_P_ARST] = r.arst_val[0];
		tri_v[`GB_P_FAN +: 4] = r.fan_ev[7:4];
		val_v[`GB_P_FAN +: 4] = r.fan_ev[3:0];
		tri_v[`GB_P_VOLT +: 4] = r.vlo_ev[7:4];
		val_v[`GB_P_VOLT +: 4] = r.vlo_ev[3:0];
		tri_v[`GB_P_VOLT + 4 +: 4] = r.vhi_ev[7:4];
		val_v[`GB_P_VOLT + 4 +: 4] = r.vhi_ev[3:0];
		tri_v[`GB_P_TEMP +: 4] = r.tmp_ev[7:4];
		val_v[`GB_P_TEMP +: 4] = r.tmp_ev[3:0];
		tri_v[`GB_P_MISC +: 4] = r.misc_ev[7:4];
		val_v[`GB_P_MISC +: 4] = r.misc_ev[3:0];
		tri_v[`GB_P_ACT] = r.act[`GB_B_ACT_OE];
		val_v[`GB_P_ACT] = r.act[0];
		tri_v[`GB_P_PCI +: 4] = r.pci_ev[7:4];
		val_v[`GB_P_PCI +: 4] = r.pci_ev[3:0];
		tri_v[`GB_P_OC +: 4] = r.oc_oe;
		tri_v[`GB_P_EV_OUT +: 6] = r.ev_dir[7:2];
		val_v[`GB_P_EV_OUT +: 6] = r.ev_val[7:2];
		tri_v[`GB_P_EV8] = r.ev8[`GB_B_EV8_DIR];
		val_v[`GB_P_EV8] = r.ev8[`GB_B_EV8_VAL];
	end

	// ownership of each pin by its dedicated function
	always_comb begin
		ded = '0;
		park = '0;
		next_hda = '0;
		for (int i = 0; i < 4; i++) begin
			next_hda[i] = (r.aud_sel[2*i +: 2] == `GB_SEL_HDA);
			ded[`GB_P_AUD + i] = next_hda[i] || (r.aud_sel[2*i +: 2] == `GB_SEL_AC97);
			ded[`GB_P_TEMP + i] = nz(r.tmp_sel[2*i +: 2]);
			ded[`GB_P_VOLT + i] = nz(r.vlo_sel[2*i +: 2]);
			ded[`GB_P_VOLT + 4 + i] = nz(r.vhi_sel[2*i +: 2]);
			ded[`GB_P_PCI + i] = !r.pci_sel[i];
		end
		// the fourth audio input has no ac97 role: 01 just parks the pin
		ded[`GB_P_AUD + 3] = next_hda[3];
		park[`GB_P_AUD + 3] = (r.aud_sel[7:6] == `GB_SEL_AC97);
		ded[`GB_P_ARST] = (r.pm_arst[1:0] != `GB_SEL_GPIO_RST);
		ded[`GB_P_FAN] = r.pm_fan[`GB_B_FANOUT2];
		ded[`GB_P_FAN + 1 +: 3] = r.fanin_sel;
		ded[`GB_P_MISC] = r.pci_bridge_config_hi[`GB_B_PCI5] || r.smb_cfg[`GB_B_BUS_MASTER_REQUEST_N];
		ded[`GB_P_MISC + 1] = r.pm_llb[`GB_B_LLB];
		ded[`GB_P_MISC + 2] = r.pci_bridge_config_hi[`GB_B_PCI5] || lpc_dma_use;
		ded[`GB_P_MISC + 3] = !rtc_internal;
		ded[`GB_P_ACT] = !r.act[`GB_B_ACT_SEL];
		ded[`GB_P_OC +: 2] = {2{smbus_oc_mode[0]}};
		ded[`GB_P_OC + 2 +: 2] = {2{smbus_oc_mode[1]}};
		ded[`GB_P_EV8] = r.ev8[`GB_B_EV8_WAKE];
	end

	// pad drive; a dedicated pin follows its function only
	always_comb begin
		for (int i = 0; i < `GB_NPIN; i++) begin
			if (ded[i]) begin
				next_oe[i] = func_oe[i];
				next_out[i] = func_out[i];
			end else begin
				next_oe[i] = !tri_v[i] && !park[i];
				next_out[i] = val_v[i];
			end
		end
		// open-collector pins only ever pull low; a function asking for high just lets go
		for (int i = `GB_P_OC; i < `GB_P_OC + 4; i++) begin
			if (ded[i]) next_oe[i] = func_oe[i] && !func_out[i];
			next_out[i] = 1'b0;
		end
		// first two event pins have no driver at all
		next_oe[`GB_P_EV +: 2] = 2'b00;
		next_out[`GB_P_EV +: 2] = 2'b00;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pad_oe <= '0;
			pad_out <= '0;
			func_sel <= '0;
			audio_hda_route <= '0;
		end else begin
			pad_oe <= next_oe;
			pad_out <= next_out;
			func_sel <= ded;
			audio_hda_route <= next_hda;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_SEL)) next_rdata = r.aud_sel;
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_IN)) next_rdata = {4'h0, st[`GB_P_AUD +: 4]};
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_ARST_IN)) next_rdata = {7'h00, st[`GB_P_ARST]};
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_OE)) next_rdata = r.aud_oe;
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_ARST_OE)) next_rdata = r.arst_oe;
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_AUD_VAL)) next_rdata = r.aud_val;
		if (hit(reg_req, GB_SP_EXT, `GB_OFF_ARST_VAL)) next_rdata = r.arst_val;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_FAN_EV)) next_rdata = r.fan_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_FAN_IN)) next_rdata = {4'h0, st[`GB_P_FAN +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_VLO_EV)) next_rdata = r.vlo_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_VLO_IN)) next_rdata = {4'h0, st[`GB_P_VOLT +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_VHI_EV)) next_rdata = r.vhi_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_VHI_IN)) next_rdata = {4'h0, st[`GB_P_VOLT + 4 +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_TMP_EV)) next_rdata = r.tmp_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_TMP_IN)) next_rdata = {4'h0, st[`GB_P_TEMP +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_PCI_EV)) next_rdata = r.pci_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_PCI_SI)) next_rdata = {r.pci_sel, st[`GB_P_PCI +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_SMB_CFG)) next_rdata = r.smb_cfg;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_MISC_EV)) next_rdata = r.misc_ev;
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_MISC_IN)) next_rdata = {4'h0, st[`GB_P_MISC +: 4]};
		if (hit(reg_req, GB_SP_SMB, `GB_OFF_ACT))
			next_rdata = {4'h0, r.act[3], st[`GB_P_ACT], r.act[1:0]};
		if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_ARST)) next_rdata = r.pm_arst;
		if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_FAN)) next_rdata = r.pm_fan;
		if (hit(reg_req, GB_SP_PM, `GB_OFF_PM_LLB)) next_rdata = r.pm_llb;
		if (hit(reg_req, GB_SP_PM, `GB_OFF_EV8)) next_rdata = {3'h0, st[`GB_P_EV8], r.ev8[3:0]};
		if (hit(reg_req, GB_SP_PM, `GB_OFF_EV_VAL)) next_rdata = r.ev_val;
		if (hit(reg_req, GB_SP_PM, `GB_OFF_EV_DIR)) next_rdata = r.ev_dir;
		if (hit(reg_req, GB_SP_PM, `GB_OFF_EV_IN)) next_rdata = st[`GB_P_EV +: 8];
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_FAN_TACH_IN_0)) next_rdata = {7'h00, r.fanin_sel[0]};
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_FANIN1)) next_rdata = {7'h00, r.fanin_sel[1]};
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_FANIN2)) next_rdata = {7'h00, r.fanin_sel[2]};
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_TMP_SEL)) next_rdata = r.tmp_sel;
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_VLO_SEL)) next_rdata = r.vlo_sel;
		if (hit(reg_req, GB_SP_PM2, `GB_OFF_VHI_SEL)) next_rdata = r.vhi_sel;
		if (hit(reg_req, GB_SP_PCI_BRIDGE_CONFIG, `GB_OFF_PCI_BRIDGE_CONFIG_HI)) next_rdata = r.pci_bridge_config_hi;
		if (hit(reg_req, GB_SP_IO, `GB_OFF_IDX)) next_rdata = r.idx;
		if (oc_data)
			next_rdata = {r.oc_oe[3:2], st[`GB_P_OC + 2 +: 2], r.oc_oe[1:0], st[`GB_P_OC +: 2]};
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_ack <= 1'b0;
		end else begin
			reg_rdata <= reg_req.rd ? next_rdata : 8'h00;
			reg_ack <= reg_req.rd;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence oc_index_write;
		reg_req.wr && hit(reg_req, GB_SP_IO, `GB_OFF_IDX) && reg_req.wdata == `GB_IDX_OC;
	endsequence

	sequence oc_data_read;
		reg_req.rd && !reg_req.wr && hit(reg_req, GB_SP_IO, `GB_OFF_DATA) && r.idx == `GB_IDX_OC;
	endsequence

	audio_gpio_drive_a: assert property (
		(r.aud_sel[1:0] inside {2'b00, 2'b11}) && !r.aud_oe[0]
		|=> pad_oe[`GB_P_AUD] && pad_out[`GB_P_AUD] == $past(r.aud_val[0]))
		else $error("audio input 0 in gpio mode not driven from its value bit");

	audio3_park_a: assert property (
		r.aud_sel[7:6] == `GB_SEL_AC97 |=> !pad_oe[`GB_P_AUD + 3] && !audio_hda_route[3])
		else $error("fourth audio input driven or routed under code 01");

	audio_reset_owner_a: assert property (
		r.pm_arst[1:0] != `GB_SEL_GPIO_RST |=> pad_oe[`GB_P_ARST] == $past(func_oe[`GB_P_ARST]))
		else $error("audio reset pin left to gpio while select is not 11");

	oc_pull_low_a: assert property (
		!smbus_oc_mode[0] && !r.oc_oe[1] |=> pad_oe[`GB_P_OC + 1] && !pad_out[`GB_P_OC + 1])
		else $error("open-collector pin 1 not pulled low with enable cleared");

	oc_index_read_a: assert property (
		oc_index_write ##[1:8] oc_data_read
		|=> reg_ack && reg_rdata[7:6] == r.oc_oe[3:2] && reg_rdata[3:2] == r.oc_oe[1:0])
		else $error("open-collector control not returned through the data port");

	event_input_only_a: assert property (
		pad_oe[`GB_P_EV +: 2] == 2'b00 && pad_out[`GB_P_EV +: 2] == 2'b00)
		else $error("input-only event pin is being driven");

	status_sync_a: assert property (
		$past(nrst) && $past(nrst, 2) |-> st == $past(pad_in, 2))
		else $error("input status not two cycles behind the pad");

	activity_gpio_a: assert property (
		r.act[`GB_B_ACT_SEL] && !r.act[`GB_B_ACT_OE] ##1 r.act[`GB_B_ACT_SEL]
		|-> pad_oe[`GB_P_ACT] && pad_out[`GB_P_ACT] == $past(r.act[0]))
		else $error("activity pin in gpio mode not driven");

	grant5_owner_a: assert property (
		r.pci_bridge_config_hi[`GB_B_PCI5] |=> func_sel[`GB_P_MISC + 2] && pad_oe[`GB_P_MISC + 2] == $past(func_oe[`GB_P_MISC + 2]))
		else $error("grant 5 pin not handed to the pci function");

	reset_inputs_a: assert property (
		$past(!nrst) |-> r.oc_oe == `GB_RST_OC && r.ev_dir == `GB_RST_ALL_IN && r.aud_oe == `GB_RST_ALL_IN)
		else $error("gpio enables not at input after reset");

	fan_out_owner_a: assert property (
		r.pm_fan[`GB_B_FANOUT2] |=> func_sel[`GB_P_FAN] && pad_out[`GB_P_FAN] == $past(func_out[`GB_P_FAN]))
		else $error("fan output pin not handed to the fan-speed function");

	voltage_owner_a: assert property (
		r.vlo_sel[1:0] != 2'b00 |=> func_sel[`GB_P_VOLT] && pad_oe[`GB_P_VOLT] == $past(func_oe[`GB_P_VOLT]))
		else $error("voltage pin 0 not handed to analog sensing");

	pci_line_gpio_a: assert property (
		r.pci_sel[0] && !r.pci_ev[4]
		|=> !func_sel[`GB_P_PCI] && pad_oe[`GB_P_PCI] && pad_out[`GB_P_PCI] == $past(r.pci_ev[0]))
		else $error("pci line pin in gpio mode not driven from its value bit");

	oc_smbus_release_a: assert property (
		smbus_oc_mode[0] && func_out[`GB_P_OC] |=> !pad_oe[`GB_P_OC] && !pad_out[`GB_P_OC])
		else $error("open-collector pin driven while its function asks for high");

	event_drive_a: assert property (
		!r.ev_dir[2] |=> pad_oe[`GB_P_EV_OUT] && pad_out[`GB_P_EV_OUT] == $past(r.ev_val[2]))
		else $error("event pin 2 not driven from its value bit");

	event8_drive_a: assert property (
		!r.ev8[`GB_B_EV8_WAKE] && !r.ev8[`GB_B_EV8_DIR]
		|=> pad_oe[`GB_P_EV8] && pad_out[`GB_P_EV8] == $past(r.ev8[`GB_B_EV8_VAL]))
		else $error("ninth event pin not driven from its value bit");

endmodule : gb_gpio_bank

// ==== gb_gpio_bank_defs.svh ====
// constants for the multiplexed gpio bank: offsets, pin map, field positions, reset values
`ifndef GB_GPIO_BANK_DEFS_SVH
`define GB_GPIO_BANK_DEFS_SVH

`define GB_NPIN 43

// pin map: base index of each pin group in the pad vectors
`define GB_P_AUD 0
`define GB_P_ARST 4
`define GB_P_FAN 5
`define GB_P_VOLT 9
`define GB_P_TEMP 17
`define GB_P_MISC 21
`define GB_P_ACT 25
`define GB_P_PCI 26
`define GB_P_OC 30
`define GB_P_EV 34
`define GB_P_EV8 42
`define GB_P_EV_OUT 36

// smbus pci configuration space
`define GB_OFF_FAN_EV 12'h050
`define GB_OFF_FAN_IN 12'h051
`define GB_OFF_VLO_EV 12'h052
`define GB_OFF_VLO_IN 12'h053
`define GB_OFF_VHI_EV 12'h054
`define GB_OFF_VHI_IN 12'h055
`define GB_OFF_TMP_EV 12'h056
`define GB_OFF_TMP_IN 12'h057
`define GB_OFF_PCI_EV 12'h05a
`define GB_OFF_PCI_SI 12'h05b
`define GB_OFF_SMB_CFG 12'h064
`define GB_OFF_MISC_EV 12'h07e
`define GB_OFF_MISC_IN 12'h07f
`define GB_OFF_ACT 12'h0ac
// smbus extended space
`define GB_OFF_AUD_SEL 12'h000
`define GB_OFF_AUD_IN 12'h002
`define GB_OFF_ARST_IN 12'h003
`define GB_OFF_AUD_OE 12'h004
`define GB_OFF_ARST_OE 12'h005
`define GB_OFF_AUD_VAL 12'h006
`define GB_OFF_ARST_VAL 12'h007
// power management space
`define GB_OFF_PM_ARST 12'h059
`define GB_OFF_PM_FAN 12'h060
`define GB_OFF_PM_LLB 12'h068
`define GB_OFF_EV8 12'h084
`define GB_OFF_EV_VAL 12'h090
`define GB_OFF_EV_DIR 12'h091
`define GB_OFF_EV_IN 12'h092
// hardware monitor space
`define GB_OFF_FAN_TACH_IN_0 12'h031
`define GB_OFF_FANIN1 12'h036
`define GB_OFF_FANIN2 12'h03b
`define GB_OFF_TMP_SEL 12'h042
`define GB_OFF_VLO_SEL 12'h056
`define GB_OFF_VHI_SEL 12'h057
// pci bridge space, byte holding bit 8 of the misc control word
`define GB_OFF_PCI_BRIDGE_CONFIG_HI 12'h065
// index/data io ports
`define GB_OFF_IDX 12'hc50
`define GB_OFF_DATA 12'hc51
`define GB_IDX_OC 8'h12

// field positions
`define GB_B_BUS_MASTER_REQUEST_N 5
`define GB_B_PCI5 0
`define GB_B_FANOUT2 3
`define GB_B_LLB 5
`define GB_B_ACT_SEL 3
`define GB_B_ACT_OE 1
`define GB_B_EV8_WAKE 0
`define GB_B_EV8_VAL 2
`define GB_B_EV8_DIR 3
`define GB_SEL_AC97 2'b01
`define GB_SEL_HDA 2'b10
`define GB_SEL_GPIO_RST 2'b11

// reset values
`define GB_RST_ZERO 8'h00
`define GB_RST_ZERO3 3'h0
`define GB_RST_ZERO4 4'h0
`define GB_RST_ALL_IN 8'hff
`define GB_RST_HI_IN 8'hf0
`define GB_RST_ARST_IN 8'h01
`define GB_RST_ACT 8'h02
`define GB_RST_EV8 8'h08
`define GB_RST_OC 4'hf

`endif

// ==== gb_pkg.sv ====
// types shared by the multiplexed gpio bank
package gb_pkg;

	typedef enum logic [2:0] {
		GB_SP_SMB = 3'b000,
		GB_SP_EXT = 3'b001,
		GB_SP_PM = 3'b010,
		GB_SP_PM2 = 3'b011,
		GB_SP_PCI_BRIDGE_CONFIG = 3'b100,
		GB_SP_IO = 3'b101
	} gb_space_t;

	typedef struct packed {
		gb_space_t space;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gb_req_t;

	typedef struct packed {
		logic [7:0] aud_sel;
		logic [7:0] aud_oe;
		logic [7:0] arst_oe;
		logic [7:0] aud_val;
		logic [7:0] arst_val;
		logic [7:0] fan_ev;
		logic [7:0] vlo_ev;
		logic [7:0] vhi_ev;
		logic [7:0] tmp_ev;
		logic [7:0] pci_ev;
		logic [3:0] pci_sel;
		logic [7:0] smb_cfg;
		logic [7:0] misc_ev;
		logic [7:0] act;
		logic [7:0] pm_arst;
		logic [7:0] pm_fan;
		logic [7:0] pm_llb;
		logic [7:0] ev8;
		logic [7:0] ev_val;
		logic [7:0] ev_dir;
		logic [2:0] fanin_sel;
		logic [7:0] tmp_sel;
		logic [7:0] vlo_sel;
		logic [7:0] vhi_sel;
		logic [7:0] pci_bridge_config_hi;
		logic [7:0] idx;
		logic [3:0] oc_oe;
	} gb_regs_t;

endpackage : gb_pkg

// ==== tb_top.sv ====
// self-checking bench for the multiplexed gpio bank
`timescale 1ns/1ns

`include "gb_gpio_bank_defs.svh"

module tb_top
	import gb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	gb_req_t req;
	logic [7:0] rdata;
	logic ack;
	logic [42:0] pad_in, pad_out, pad_oe, func_out, func_oe, func_sel, ext_lvl;
	logic [3:0] hda;
	logic [1:0] oc_mode;
	logic lpc_use, rtc_int;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;

	always #5 sys_clk = ~sys_clk;

	gb_gpio_bank DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata), .reg_ack(ack),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .func_out(func_out), .func_oe(func_oe),
		.func_sel(func_sel), .audio_hda_route(hda), .smbus_oc_mode(oc_mode), .lpc_dma_use(lpc_use),
		.rtc_internal(rtc_int));
	gb_board_model board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .pad_in(pad_in));

	task automatic wrap_up();
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// a write lands at the first edge; pads follow one edge later, so wait that out
	task automatic wr(input gb_space_t sp, input logic [11:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req = '{space: sp, addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge sys_clk);
		req.wr = 1'b0;
		@(negedge sys_clk);
	endtask : wr

	// leading idle cycles let pin changes clear the input synchronisers first
	task automatic rd(input gb_space_t sp, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		repeat (3) @(negedge sys_clk);
		req = '{space: sp, addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge sys_clk);
		// ack and data stand only from the edge after the request to the next one
		chk({ack, rdata & m}, {1'b1, e});
		req.rd = 1'b0;
	endtask : rd

	task automatic t_reset();
		chk({pad_oe[42:30], pad_oe[24:5], pad_oe[3:0]}, 37'h0);
		chk({func_sel[29:25], func_sel[4]}, 6'h3f);
		rd(GB_SP_EXT, `GB_OFF_AUD_OE, 8'hff, 8'hff);
		rd(GB_SP_SMB, `GB_OFF_FAN_EV, 8'hf0, 8'hf0);
		rd(GB_SP_PM, `GB_OFF_EV_DIR, 8'hff, 8'hff);
		rd(GB_SP_PM, `GB_OFF_EV8, 8'hff, 8'h08);
		rd(GB_SP_SMB, `GB_OFF_ACT, 8'hff, 8'h06);
		wr(GB_SP_IO, `GB_OFF_IDX, `GB_IDX_OC);
		rd(GB_SP_IO, `GB_OFF_DATA, 8'hff, 8'hff);
	endtask : t_reset

	task automatic t_audio();
		logic gp;
		wr(GB_SP_EXT, `GB_OFF_AUD_OE, 8'h00);
		wr(GB_SP_EXT, `GB_OFF_AUD_VAL, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(GB_SP_EXT, `GB_OFF_AUD_SEL, {4{c[1:0]}});
			wr(GB_SP_PM, `GB_OFF_PM_ARST, {6'h00, c[1:0]});
			gp = (c == 0 || c == 3);
			chk({pad_oe[2:0], pad_out[2:0]}, gp ? 6'h38 : 6'h3f);
			chk(hda, (c == 2) ? 4'hf : 4'h0);
			chk(pad_oe[3], c != 1);
			chk(func_sel[4], c != 3);
		end
		wr(GB_SP_EXT, `GB_OFF_AUD_VAL, 8'h05);
		rd(GB_SP_EXT, `GB_OFF_AUD_IN, 8'h0f, 8'h05);
		ext_lvl[3:0] = 4'ha;
		wr(GB_SP_EXT, `GB_OFF_AUD_OE, 8'h0f);
		chk(pad_oe[3:0], 4'h0);
		rd(GB_SP_EXT, `GB_OFF_AUD_IN, 8'h0f, 8'h0a);
	endtask : t_audio

	task automatic t_fan_mon();
		wr(GB_SP_SMB, `GB_OFF_FAN_EV, 8'h0a);
		chk({pad_oe[8:5], pad_out[8:5]}, 8'hfa);
		rd(GB_SP_SMB, `GB_OFF_FAN_IN, 8'h0f, 8'h0a);
		wr(GB_SP_PM, `GB_OFF_PM_FAN, 8'h08);
		chk({func_sel[5], pad_out[5]}, 2'b11);
		rd(GB_SP_SMB, `GB_OFF_FAN_IN, 8'h01, 8'h01);
		for (int c = 0; c < 4; c++) begin
			wr(GB_SP_PM2, `GB_OFF_VLO_SEL, {4{c[1:0]}});
			wr(GB_SP_PM2, `GB_OFF_VHI_SEL, {4{c[1:0]}});
			wr(GB_SP_PM2, `GB_OFF_TMP_SEL, {4{c[1:0]}});
			chk(func_sel[20:9], (c == 0) ? 12'h000 : 12'hfff);
		end
		wr(GB_SP_PM2, `GB_OFF_FANIN1, 8'h01);
		chk({func_sel[8:6], pad_oe[7]}, 4'b0101);
	endtask : t_fan_mon

	task automatic t_event();
		ext_lvl[35:34] = 2'b01;
		wr(GB_SP_PM, `GB_OFF_EV_DIR, 8'h00);
		wr(GB_SP_PM, `GB_OFF_EV_VAL, 8'ha7);
		chk(pad_oe[41:34], 8'hfc);
		chk(pad_out[41:36], 6'h29);
		rd(GB_SP_PM, `GB_OFF_EV_IN, 8'hff, 8'ha5);
		wr(GB_SP_PM, `GB_OFF_EV8, 8'h04);
		chk({pad_oe[42], pad_out[42]}, 2'b11);
		rd(GB_SP_PM, `GB_OFF_EV8, 8'hff, 8'h14);
		wr(GB_SP_PM, `GB_OFF_EV8, 8'h08);
		chk(pad_oe[42], 1'b0);
		rd(GB_SP_PM, `GB_OFF_EV8, 8'hff, 8'h08);
	endtask : t_event

	task automatic t_oc();
		wr(GB_SP_IO, `GB_OFF_DATA, 8'h44);
		chk({pad_oe[33:30], pad_out[33], pad_out[31]}, 6'b101000);
		rd(GB_SP_IO, `GB_OFF_DATA, 8'hff, 8'h55);
		wr(GB_SP_IO, 12'hc52, 8'h00);
		rd(GB_SP_IO, 12'hc52, 8'hff, 8'h00);
		@(negedge sys_clk);
		oc_mode = 2'b01;
		repeat (2) @(negedge sys_clk);
		chk(func_sel[31:30], 2'b11);
		chk({pad_oe[31:30], pad_out[31:30]}, 4'h0);
		func_out[30] = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({pad_oe[31:30], pad_out[31:30]}, 4'h4);
		func_out[30] = 1'b1;
	endtask : t_oc

	task automatic t_pci();
		wr(GB_SP_SMB, `GB_OFF_MISC_EV, 8'h00);
		chk({pad_oe[24:21], pad_out[24:21]}, 8'hf0);
		wr(GB_SP_SMB, `GB_OFF_SMB_CFG, 8'h20);
		chk({func_sel[21], pad_out[21]}, 2'b11);
		wr(GB_SP_PCI_BRIDGE_CONFIG, `GB_OFF_PCI_BRIDGE_CONFIG_HI, 8'h01);
		chk({func_sel[23], func_sel[21]}, 2'b11);
		wr(GB_SP_PCI_BRIDGE_CONFIG, `GB_OFF_PCI_BRIDGE_CONFIG_HI, 8'h00);
		wr(GB_SP_SMB, `GB_OFF_SMB_CFG, 8'h00);
		chk({func_sel[23], func_sel[21]}, 2'b00);
		lpc_use = 1'b1;
		rtc_int = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(func_sel[24:23], 2'b11);
		wr(GB_SP_SMB, `GB_OFF_PCI_SI, 8'hf0);
		wr(GB_SP_SMB, `GB_OFF_PCI_EV, 8'h05);
		chk({pad_oe[29:26], pad_out[29:26]}, 8'hf5);
		rd(GB_SP_SMB, `GB_OFF_PCI_SI, 8'hff, 8'hf5);
		wr(GB_SP_SMB, `GB_OFF_ACT, 8'h09);
		chk({func_sel[25], pad_oe[25], pad_out[25]}, 3'b011);
		rd(GB_SP_SMB, `GB_OFF_ACT, 8'hff, 8'h0d);
		wr(GB_SP_PM, `GB_OFF_PM_LLB, 8'h20);
		chk({func_sel[22], pad_oe[22]}, 2'b11);
	endtask : t_pci

	// cycle ceiling well above the few hundred cycles the scenarios need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		req = '0;
		func_out = '1;
		func_oe = '1;
		ext_lvl = '0;
		oc_mode = 2'b00;
		lpc_use = 1'b0;
		rtc_int = 1'b1;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (2) @(negedge sys_clk);
		t_reset();
		t_audio();
		t_fan_mon();
		t_event();
		t_oc();
		t_pci();
		wrap_up();
	end
endmodule : tb_top
